// ### bts_ctrl.v
// Brown-out detector and thermal sensor control register bank
`timescale 1ns/10ps
`default_nettype none
`include "bts_consts.vh"
module bts_ctrl
(
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // Configuration and write lock
   input wire [31:0] user_config_word0,
   input wire write_unlocked,
   // Analog detector and sensor
   input wire comparator_below,
   output reg [1:0] comparator_level_sel,
   output reg detector_enable,
   output reg thermal_to_adc,
   output reg brownout_reset_req,
   output reg irq
);

   // ************************************
   // Registers
   // ************************************
   // Software-visible fields and their next values
   reg detect_on_r;
   reg detect_on_nxt;
   reg [1:0] threshold_sel_r;
   reg [1:0] threshold_sel_nxt;
   reg action_sel_r;
   reg action_sel_nxt;
   reg thermal_on_r;
   reg thermal_on_nxt;
   reg [`BTS_IRQ_WIDTH-1:0] irq_mask_r;
   reg [`BTS_IRQ_WIDTH-1:0] irq_mask_nxt;
   // Detector status, kept one cycle so that both crossings can be seen
   reg status_r;
   // Sticky event flags
   reg [`BTS_IRQ_WIDTH-1:0] irq_stat_r;
   // High from reset until the strap word has been copied
   reg load_pending_r;
   // Read multiplexer output
   reg [31:0] rd_nxt;

   // ************************************
   // Decoding helpers
   // ************************************
   // Full byte-address compare, so no register shows up at an alias
   function sel_hit;
      input [7:0] adr;
      input [7:0] off;
      begin
         sel_hit = (adr == off);
      end
   endfunction

   // Write strobe for one offset
   function wr_hit;
      input wr_en;
      input [7:0] adr;
      input [7:0] off;
      begin
         wr_hit = wr_en & sel_hit(adr, off);
      end
   endfunction

   // Packs the brown-out control word for a read
   function [31:0] brownout_word;
      input detect_on;
      input [1:0] threshold_sel;
      input action_sel;
      input status;
      begin
         brownout_word = 32'h0000_0000;
         brownout_word[`BTS_BIT_DETECT_ON] = detect_on;
         brownout_word[`BTS_BIT_THR_HI:`BTS_BIT_THR_LO] = threshold_sel;
         brownout_word[`BTS_BIT_ACTION] = action_sel;
         brownout_word[`BTS_BIT_STATUS] = status;
      end
   endfunction

   // Packs the thermal word; bits above the enable are reserved
   function [31:0] thermal_word;
      input thermal_on;
      begin
         thermal_word = 32'h0000_0000;
         thermal_word[`BTS_BIT_THERMAL_ON] = thermal_on;
      end
   endfunction

   // ************************************
   // Bus decode
   // ************************************
   // A request is taken only while ack is low, so one strobe makes one access
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // Every field sits in byte lane 0; a write without that lane is dropped
   wire wr = req & wb_we_i & wb_sel_i[0];
   // A locked write is still acknowledged, it just changes nothing
   wire wr_bo = wr_hit(wr, wb_adr_i, `BTS_OFF_BROWNOUT) & write_unlocked;
   wire wr_thermal = wr_hit(wr, wb_adr_i, `BTS_OFF_THERMAL);
   // Flag clears and mask writes are not protected
   wire wr_stat = wr_hit(wr, wb_adr_i, `BTS_OFF_IRQ_STAT);
   wire wr_mask = wr_hit(wr, wb_adr_i, `BTS_OFF_IRQ_MASK);

   // ************************************
   // Detector status and events
   // ************************************
   // Forced low while the detector is off, whatever the comparator shows
   wire status_nxt = detect_on_r & comparator_below;
   wire [`BTS_IRQ_WIDTH-1:0] irq_event;
   wire [`BTS_IRQ_WIDTH-1:0] irq_stat_nxt;
   wire [`BTS_IRQ_WIDTH-1:0] irq_pending;
   // Supply has just fallen below the selected level
   assign irq_event[`BTS_IRQ_BELOW] = status_nxt & ~status_r;
   // Either crossing; switching the detector off while low counts as one too
   assign irq_event[`BTS_IRQ_CROSS] = status_nxt ^ status_r;

   // Set wins over a same-cycle clear, so an event is never lost
   genvar i;
   generate
      for (i = 0; i < `BTS_IRQ_WIDTH; i = i + 1)
      begin : g_irq_bit
         assign irq_stat_nxt[i] = irq_event[i] | (irq_stat_r[i] & ~(wr_stat & wb_dat_i[i]));
         assign irq_pending[i] = irq_stat_nxt[i] & irq_mask_r[i];
      end
   endgenerate

   // ************************************
   // Control field next state
   // ************************************
   // The strap copy outranks a write that lands in the same cycle
   always @*
   begin
      detect_on_nxt = detect_on_r;
      threshold_sel_nxt = threshold_sel_r;
      action_sel_nxt = action_sel_r;
      if (load_pending_r)
      begin
         action_sel_nxt = user_config_word0[`BTS_CFG_ACTION];
         threshold_sel_nxt = user_config_word0[`BTS_CFG_THR_HI:`BTS_CFG_THR_LO];
         detect_on_nxt = user_config_word0[`BTS_CFG_DETECT];
      end
      else if (wr_bo)
      begin
         action_sel_nxt = wb_dat_i[`BTS_BIT_ACTION];
         threshold_sel_nxt = wb_dat_i[`BTS_BIT_THR_HI:`BTS_BIT_THR_LO];
         detect_on_nxt = wb_dat_i[`BTS_BIT_DETECT_ON];
      end
   end

   // The sensor enable is not write protected
   always @*
   begin
      thermal_on_nxt = thermal_on_r;
      if (wr_thermal)
      begin
         thermal_on_nxt = wb_dat_i[`BTS_BIT_THERMAL_ON];
      end
   end

   // Mask bits only gate the output; flags still set while masked
   always @*
   begin
      irq_mask_nxt = irq_mask_r;
      if (wr_mask)
      begin
         irq_mask_nxt = wb_dat_i[`BTS_IRQ_WIDTH-1:0];
      end
   end

   // ************************************
   // Control field registers
   // ************************************
   // Reset loads constants only; the strap word may not be valid while reset is low
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         load_pending_r <= 1'b1;
         detect_on_r <= `BTS_DETECT_RESET;
         threshold_sel_r <= `BTS_THR_2V2;
         action_sel_r <= `BTS_ACTION_RESET;
         thermal_on_r <= `BTS_THERMAL_RESET;
         irq_mask_r <= {`BTS_IRQ_WIDTH{1'b0}};
      end
      else
      begin
         load_pending_r <= 1'b0;
         detect_on_r <= detect_on_nxt;
         threshold_sel_r <= threshold_sel_nxt;
         action_sel_r <= action_sel_nxt;
         thermal_on_r <= thermal_on_nxt;
         irq_mask_r <= irq_mask_nxt;
      end
   end

   // ************************************
   // Status and event flag registers
   // ************************************
   // The status lags the comparator by one cycle
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status_r <= 1'b0;
         irq_stat_r <= {`BTS_IRQ_WIDTH{1'b0}};
      end
      else
      begin
         status_r <= status_nxt;
         irq_stat_r <= irq_stat_nxt;
      end
   end

   // ************************************
   // Read multiplexer
   // ************************************
   // Reserved bits and unmapped offsets read as zero
   always @*
   begin
      rd_nxt = 32'h0000_0000;
      case (wb_adr_i)
         `BTS_OFF_BROWNOUT:
         begin
            rd_nxt = brownout_word(detect_on_r, threshold_sel_r, action_sel_r, status_r);
         end
         `BTS_OFF_THERMAL:
         begin
            rd_nxt = thermal_word(thermal_on_r);
         end
         `BTS_OFF_IRQ_STAT:
         begin
            rd_nxt[`BTS_IRQ_WIDTH-1:0] = irq_stat_r;
         end
         `BTS_OFF_IRQ_MASK:
         begin
            rd_nxt[`BTS_IRQ_WIDTH-1:0] = irq_mask_r;
         end
         default:
         begin
            rd_nxt = 32'h0000_0000;
         end
      endcase
   end

   // ************************************
   // Bus answer
   // ************************************
   // One wait state; unmapped offsets still ack so a stray access cannot hang the bus
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= req;
         // Data is zero outside the ack cycle
         wb_dat_o <= req ? rd_nxt : 32'h0000_0000;
      end
   end

   // ************************************
   // Analog side and interrupt outputs
   // ************************************
   // All outputs are registered; each lags its field by one cycle, except irq, which is built from the next flag value and changes with its flag
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         comparator_level_sel <= `BTS_THR_2V2;
         detector_enable <= 1'b0;
         thermal_to_adc <= 1'b0;
         brownout_reset_req <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         // The comparator and sensor see the fields only after the strap copy
         comparator_level_sel <= threshold_sel_r;
         detector_enable <= detect_on_r;
         thermal_to_adc <= thermal_on_r;
         // Follows the comparator directly, not the registered status, to save a cycle
         brownout_reset_req <= detect_on_r & action_sel_r & comparator_below;
         // Level output: stays high until software clears the flag or masks it
         irq <= |irq_pending;
      end
   end

endmodule
`default_nettype wire

// ### bts_consts.vh
// Constants for the brown-out and thermal sensor control block
`ifndef BTS_CONSTS_VH
`define BTS_CONSTS_VH
// Register byte offsets
`define BTS_OFF_BROWNOUT 8'h18
`define BTS_OFF_THERMAL 8'h1C
`define BTS_OFF_IRQ_STAT 8'h40
`define BTS_OFF_IRQ_MASK 8'h44
// Brown-out control field positions
`define BTS_BIT_DETECT_ON 0
`define BTS_BIT_THR_LO 1
`define BTS_BIT_THR_HI 2
`define BTS_BIT_ACTION 3
`define BTS_BIT_STATUS 6
// User configuration word field positions
`define BTS_CFG_ACTION 20
`define BTS_CFG_THR_LO 21
`define BTS_CFG_THR_HI 22
`define BTS_CFG_DETECT 23
// Thermal control field position and reset value
`define BTS_BIT_THERMAL_ON 0
`define BTS_THERMAL_RESET 1'b0
// Brown-out field values held until the strap copy
`define BTS_DETECT_RESET 1'b0
`define BTS_ACTION_RESET 1'b0
// Interrupt status bits
`define BTS_IRQ_BELOW 0
`define BTS_IRQ_CROSS 1
`define BTS_IRQ_WIDTH 2
// Threshold codes
`define BTS_THR_2V2 2'h0
`define BTS_THR_2V7 2'h1
`define BTS_THR_3V7 2'h2
`define BTS_THR_4V4 2'h3
`endif

// ### bts_ctrl_asserts.sv
// Checker bound to the brown-out and thermal sensor control block
`timescale 1ns/10ps
`default_nettype none
module bts_ctrl_chk (
   // Bus
   input wire logic clk, input wire logic rst_n, input wire logic wb_cyc_i, input wire logic wb_stb_i,
   input wire logic wb_we_i, input wire logic [7:0] wb_adr_i, input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_o, input wire logic wb_ack_o,
   // Configuration and analog side
   input wire logic [31:0] user_config_word0, input wire logic write_unlocked, input wire logic comparator_below,
   input wire logic [1:0] comparator_level_sel, input wire logic detector_enable, input wire logic thermal_to_adc,
   input wire logic brownout_reset_req, input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire thermal_wr = wb_we_i && wb_adr_i == 8'h1C && wb_ack_o;
   a_ack_follows: assert property (take |=> wb_ack_o) else $error("no ack after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("read data without ack");
   a_lock_holds: assert property (take && wb_we_i && wb_adr_i == 8'h18 && !write_unlocked |=> ##1
      $stable(detector_enable) && $stable(comparator_level_sel)) else $error("locked write took effect");
   a_strap_load: assert property ($rose(rst_n) |-> ##2 detector_enable == user_config_word0[23] &&
      comparator_level_sel == user_config_word0[22:21]) else $error("strap defaults not loaded");
   a_below_needed: assert property (!comparator_below |=> !brownout_reset_req) else $error("reset without low supply");
   a_off_quiet: assert property (!detector_enable && $past(!detector_enable) |-> !brownout_reset_req)
      else $error("reset while detector off");
   a_thermal_cause: assert property ($changed(thermal_to_adc) |-> $past(thermal_wr) || $past(thermal_wr, 2))
      else $error("sensor routing changed without write");
   c_locked_wr: cover property (take && wb_we_i && !write_unlocked);
   c_reset_req: cover property (brownout_reset_req);
   c_irq: cover property (irq);
endmodule
bind bts_ctrl bts_ctrl_chk i_chk (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .user_config_word0(user_config_word0), .write_unlocked(write_unlocked), .comparator_below(comparator_below),
   .comparator_level_sel(comparator_level_sel), .detector_enable(detector_enable), .thermal_to_adc(thermal_to_adc),
   .brownout_reset_req(brownout_reset_req), .irq(irq));
`default_nettype wire

// ### bts_ctrl_tb.sv
// Self-checking testbench for the brown-out and thermal sensor control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module bts_ctrl_tb;
   logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, unl = 0, below = 0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hF;
   logic [31:0] din = 32'h0000_0000, q, cfg = 32'h00D0_0000;
   wire [31:0] dato;
   wire [1:0] lvl;
   wire ack, det, therm, breq, irq;
   int fail_count = 0, num_checks = 0;
   bts_ctrl i_bts_ctrl (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(din), .wb_dat_o(dato), .wb_ack_o(ack), .user_config_word0(cfg),
      .write_unlocked(unl), .comparator_below(below), .comparator_level_sel(lvl), .detector_enable(det),
      .thermal_to_adc(therm), .brownout_reset_req(breq), .irq(irq));
   always #25 clk = ~clk;
   // Holds the request until ack is sampled; three idle edges plus the next call's edge make stb drop for four cycles
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      begin
         @(posedge clk);
         cyc <= 1; stb <= 1; we <= w; adr <= a; din <= d;
         n = 0;
         do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
         if (ack !== 1'b1) begin fail_count++; $display("[ERR] ack exp 1 got %b", ack); end
         q = dato;
         cyc <= 0; stb <= 0;
         repeat (3) @(posedge clk);
      end
   endtask
   task t_strap;
      begin
         bus(0, 8'h18, 0); `CHK("strap", 32'h0000_000D, q)
         `CHK("level", 2'h2, lvl)
         `CHK("detect out", 1'b1, det)
         bus(0, 8'h1C, 0); `CHK("thermal reset", 32'h0000_0000, q)
         bus(0, 8'h80, 0); `CHK("unmapped", 32'h0000_0000, q)
      end
   endtask
   task t_lock;
      begin
         bus(1, 8'h18, 0); bus(0, 8'h18, 0); `CHK("locked", 32'h0000_000D, q)
         unl <= 1; bus(1, 8'h18, 32'h0000_0003); bus(0, 8'h18, 0); `CHK("unlocked", 32'h0000_0003, q)
         `CHK("level 01", 2'h1, lvl)
      end
   endtask
   task t_thermal;
      begin
         bus(1, 8'h1C, 32'hFFFF_FFFF); bus(0, 8'h1C, 0); `CHK("thermal", 32'h0000_0001, q)
         `CHK("adc route", 1'b1, therm)
      end
   endtask
   task t_brown;
      begin
         bus(1, 8'h18, 32'h0000_0009); below <= 1; bus(1, 8'h44, 32'h0000_0001);
         `CHK("reset req", 1'b1, breq)
         `CHK("irq", 1'b1, irq)
         bus(0, 8'h18, 0); `CHK("status on", 32'h0000_0049, q)
         bus(0, 8'h40, 0); `CHK("irq flags", 32'h0000_0003, q)
         bus(0, 8'h44, 0); `CHK("irq mask", 32'h0000_0001, q)
         bus(1, 8'h18, 32'h0000_0008); bus(0, 8'h18, 0); `CHK("status off", 32'h0000_0008, q)
         `CHK("no req", 1'b0, breq)
         `CHK("detect off", 1'b0, det)
         bus(1, 8'h40, 32'h0000_0003); bus(0, 8'h40, 0); `CHK("w1c", 32'h0000_0000, q)
         `CHK("irq clear", 1'b0, irq)
      end
   endtask
   task test_done;
      begin
         $display("checks %0d mismatches %0d", num_checks, fail_count);
         if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
         else $display("Testbench failed");
         $finish;
      end
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      rst_n <= 1;
      repeat (2) @(posedge clk);
      t_strap; t_lock; t_thermal; t_brown;
      test_done;
   end
   initial
   begin
      #200000;
      fail_count++;
      test_done;
   end
endmodule
`default_nettype wire
